// *** hw/watchdog_host.sv ***
// Host-side trigger generator: pulses the trigger low once per period.
// Assumes reset_n from the watchdog is asynchronous to sys_clk.

`include "wdog_map.svh"
module watchdog_host #(
	parameter int PERIOD_CYCLES = `HOST_PERIOD_CYC,
	parameter int PULSE_CYCLES = `HOST_PULSE_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// User side
	input wire logic trigger_enable,
	output logic in_reset,
	// Watchdog link
	wdog_link_if.host link
);

	logic [1:0] nres_sync_reg;
	logic [31:0] per_cnt_reg;
	logic trig_n_reg;
	logic in_reset_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			nres_sync_reg <= 2'h0;
		else
			nres_sync_reg <= {nres_sync_reg[0], link.reset_n};
	end

	// Period counting restarts on each reset release, so the first trigger lands
	// well inside the lead time and later ones mid-window
	always_ff @(posedge sys_clk)
	begin
		if (rst || !nres_sync_reg[1] || per_cnt_reg == 32'(PERIOD_CYCLES - 1))
			per_cnt_reg <= 32'h0000_0000;
		else
			per_cnt_reg <= per_cnt_reg + 32'h0000_0001;
	end

	// Low pulse kept well above the glitch limit; the enable only gates the start
	// of a pulse, so dropping it never leaves a glitch-length low on the pin
	always_ff @(posedge sys_clk)
	begin
		if (rst || !nres_sync_reg[1])
			trig_n_reg <= 1'b1;
		else
			trig_n_reg <= !(per_cnt_reg >= 32'(PERIOD_CYCLES - PULSE_CYCLES)
				&& (trigger_enable || !trig_n_reg));
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			in_reset_reg <= 1'b1;
		else
			in_reset_reg <= !nres_sync_reg[1];
	end

	assign link.watchdog_trigger_n = trig_n_reg;
	assign in_reset = in_reset_reg;

endmodule

// *** hw/wdog_link_if.sv ***
// Link between the watchdog and the host microcontroller.
// Assumes both ends run on sys_clk; pins are plain one-way wires.
interface wdog_link_if;
	logic watchdog_trigger_n;
	logic reset_n;
	modport device (input watchdog_trigger_n, output reset_n);
	modport host (output watchdog_trigger_n, input reset_n);
endinterface

// *** hw/wdog_map.svh ***
// Timing constants for the window watchdog and its host-side trigger generator.
// Assumes a 100 MHz system clock; oscillator period is a multiple of that clock.
`ifndef WDOG_MAP_SVH
`define WDOG_MAP_SVH

`define SYS_CLK_PERIOD_NS 10
`define TRIG_MIN_NS 200
`define TRIG_MIN_CYC ((`TRIG_MIN_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define LEAD_OSC_PERIODS 7895
`define CLOSED_OSC_PERIODS 1053
`define OPEN_OSC_PERIODS 1105
`define NRES_MS 4
`define NRES_CYC (`NRES_MS * 1000000 / `SYS_CLK_PERIOD_NS)
`define POR_MS 4
`define POR_CYC (`POR_MS * 1000000 / `SYS_CLK_PERIOD_NS)
`define OSC_PERIOD_NS 19600
`define OSC_DIV_CYC (`OSC_PERIOD_NS / `SYS_CLK_PERIOD_NS)
`define HOST_PERIOD_NS 29300000
`define HOST_PERIOD_CYC (`HOST_PERIOD_NS / `SYS_CLK_PERIOD_NS)
`define HOST_PULSE_NS 1000
`define HOST_PULSE_CYC (`HOST_PULSE_NS / `SYS_CLK_PERIOD_NS)

`endif

// *** hw/wdog_pkg.sv ***
// Types used by the watchdog end of the link.
// Assumes nothing beyond a SystemVerilog compiler.
package wdog_pkg;
	typedef enum logic [2:0] {
		ST_POR,
		ST_LEAD,
		ST_CLOSED,
		ST_OPEN,
		ST_RESET,
		ST_OFF
	} wd_state_e;
endpackage

// *** hw/window_watchdog.sv ***
// Window watchdog: lead time, closed window, open window and reset pulse.
// Assumes the trigger and mode/wake pins are asynchronous and synchronises them.

`include "wdog_map.svh"

module window_watchdog #(
	parameter int OSC_DIV = `OSC_DIV_CYC,
	parameter int LEAD_PERIODS = `LEAD_OSC_PERIODS,
	parameter int CLOSED_PERIODS = `CLOSED_OSC_PERIODS,
	parameter int OPEN_PERIODS = `OPEN_OSC_PERIODS,
	parameter int NRES_CYCLES = `NRES_CYC,
	parameter int POR_CYCLES = `POR_CYC
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Chip mode and wake-up
	input wire logic low_power_mode,
	input wire logic receive_data,
	// Host link
	wdog_link_if.device link
);

	////////////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic [1:0] trig_sync_reg;
	logic [1:0] lp_sync_reg;
	logic [1:0] rxd_sync_reg;
	logic rxd_prev_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			trig_sync_reg <= 2'h3;
			lp_sync_reg <= 2'h0;
			rxd_sync_reg <= 2'h3;
			rxd_prev_reg <= 1'b1;
		end
		else
		begin
			trig_sync_reg <= {trig_sync_reg[0], link.watchdog_trigger_n};
			lp_sync_reg <= {lp_sync_reg[0], low_power_mode};
			rxd_sync_reg <= {rxd_sync_reg[0], receive_data};
			rxd_prev_reg <= rxd_sync_reg[1];
		end
	end

	logic rxd_fall;
	assign rxd_fall = rxd_prev_reg & ~rxd_sync_reg[1];

	////////////////////////////////////////////////////////////////////////////////
	// Glitch filter: a low lasting the minimum width counts as one trigger

	localparam int TRIG_MIN = `TRIG_MIN_CYC;
	logic [7:0] low_cnt_reg;
	logic trig_valid;

	always_ff @(posedge sys_clk)
	begin
		if (rst || trig_sync_reg[1])
			low_cnt_reg <= 8'h00;
		else if (low_cnt_reg != 8'(TRIG_MIN))
			low_cnt_reg <= low_cnt_reg + 8'h01;
	end

	// One pulse when the low has been seen for the full minimum width
	assign trig_valid = ~trig_sync_reg[1] && (low_cnt_reg == 8'(TRIG_MIN - 1));

	////////////////////////////////////////////////////////////////////////////////
	// Oscillator period tick

	logic [15:0] div_reg;
	logic osc_tick;
	logic clear_cnt;

	assign osc_tick = (div_reg == 16'(OSC_DIV - 1));

	// Divider restarts with each interval so every window is whole periods long
	always_ff @(posedge sys_clk)
	begin
		if (rst || clear_cnt || osc_tick)
			div_reg <= 16'h0000;
		else
			div_reg <= div_reg + 16'h0001;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sequencer

	wdog_pkg::wd_state_e state_reg, state_next;
	logic [31:0] cnt_reg;

	assign clear_cnt = (state_next != state_reg);

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			wdog_pkg::ST_POR:
				if (cnt_reg == 32'(POR_CYCLES - 1))
					state_next = wdog_pkg::ST_LEAD;
			wdog_pkg::ST_LEAD:
				if (trig_valid)
					state_next = wdog_pkg::ST_CLOSED;
				else if (osc_tick && cnt_reg == 32'(LEAD_PERIODS - 1))
					state_next = wdog_pkg::ST_RESET;
			wdog_pkg::ST_CLOSED:
				if (trig_valid)
					state_next = wdog_pkg::ST_RESET;
				else if (osc_tick && cnt_reg == 32'(CLOSED_PERIODS - 1))
					state_next = wdog_pkg::ST_OPEN;
			wdog_pkg::ST_OPEN:
				if (trig_valid)
					state_next = wdog_pkg::ST_CLOSED;
				else if (osc_tick && cnt_reg == 32'(OPEN_PERIODS - 1))
					state_next = wdog_pkg::ST_RESET;
			wdog_pkg::ST_RESET:
				// Triggers are not looked at while the pulse is out
				if (cnt_reg == 32'(NRES_CYCLES - 1))
					state_next = wdog_pkg::ST_LEAD;
			wdog_pkg::ST_OFF:
				if (!lp_sync_reg[1] && rxd_fall)
					state_next = wdog_pkg::ST_LEAD;
			default:
				state_next = wdog_pkg::ST_POR;
		endcase
		// Low-power mode wins over everything except the power-on hold
		if (lp_sync_reg[1] && state_reg != wdog_pkg::ST_POR)
			state_next = wdog_pkg::ST_OFF;
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			state_reg <= wdog_pkg::ST_POR;
		else
			state_reg <= state_next;
	end

	// Intervals in windows count oscillator ticks; reset pulses count sys_clk
	// so their length is constant whatever the oscillator does
	always_ff @(posedge sys_clk)
	begin
		if (rst || clear_cnt)
			cnt_reg <= 32'h0000_0000;
		else if (state_reg == wdog_pkg::ST_POR || state_reg == wdog_pkg::ST_RESET)
			cnt_reg <= cnt_reg + 32'h0000_0001;
		else if (osc_tick && state_reg != wdog_pkg::ST_OFF)
			cnt_reg <= cnt_reg + 32'h0000_0001;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reset output

	logic nres_reg;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			nres_reg <= 1'b0;
		else
			nres_reg <= !(state_next == wdog_pkg::ST_POR || state_next == wdog_pkg::ST_RESET);
	end

	assign link.reset_n = nres_reg;

endmodule

// *** tb/test_window_watchdog.sv ***
// Bench: host and watchdog on link a, bench-driven trigger on link b.
// Assumes shortened oscillator counts so the run stays short.
module test_window_watchdog;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int L = 80;
	localparam int NR = 50;
	logic sys_clk = 0, rst = 1, trig_en = 0, lp_a = 0, lp_b = 0, rx_a = 1, rx_b = 1;
	int num_errors = 0, cmp_count = 0, low_a = 0, low_b = 0, n;
	time t0;
	wdog_link_if la();
	wdog_link_if lb();
	window_watchdog #(.OSC_DIV(4), .LEAD_PERIODS(20), .CLOSED_PERIODS(5), .OPEN_PERIODS(6), .NRES_CYCLES(NR),
		.POR_CYCLES(NR)) u_window_watchdog (.sys_clk(sys_clk), .rst(rst), .low_power_mode(lp_a),
		.receive_data(rx_a), .link(la));
	// Wider closed window on b so a second trigger can land inside it
	window_watchdog #(.OSC_DIV(4), .LEAD_PERIODS(20), .CLOSED_PERIODS(15), .OPEN_PERIODS(10), .NRES_CYCLES(NR),
		.POR_CYCLES(NR)) u_window_watchdog_b (.sys_clk(sys_clk), .rst(rst), .low_power_mode(lp_b),
		.receive_data(rx_b), .link(lb));
	watchdog_host #(.PERIOD_CYCLES(28), .PULSE_CYCLES(25)) u_watchdog_host (.sys_clk(sys_clk), .rst(rst),
		.trigger_enable(trig_en), .in_reset(), .link(la));
	window_watchdog_properties #(.NRES_CYCLES(NR), .POR_CYCLES(NR)) u_window_watchdog_properties (.sys_clk(sys_clk),
		.rst(rst), .low_power_mode(lp_a), .watchdog_trigger_n(la.watchdog_trigger_n), .reset_n(la.reset_n));
	initial forever #5 sys_clk = ~sys_clk;
	always @(negedge sys_clk)
	begin
		low_a += int'(la.reset_n !== 1'b1);
		low_b += int'(lb.reset_n !== 1'b1);
	end
	////////////////////////////////////////////////////////////////
	task test_done;
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task chk(input string s, input int lo, input int hi, input int v);
		cmp_count++;
		if (v < lo || v > hi)
		begin
			num_errors++;
			$display("FAIL %s expected %0d..%0d seen %0d", s, lo, hi, v);
		end
	endtask
	function int el();
		return int'(($time - t0) / 10);
	endfunction
	task cyc(input int k);
		repeat (k) @(posedge sys_clk);
	endtask
	task wt(input logic v);
		for (int k = 0; k < 3000 && lb.reset_n !== v; k++)
			@(negedge sys_clk);
	endtask
	task pulse(input int lo, input int hi);
		@(posedge sys_clk);
		lb.watchdog_trigger_n <= 1'b0;
		cyc(lo);
		lb.watchdog_trigger_n <= 1'b1;
		cyc(hi);
	endtask
	////////////////////////////////////////////////////////////////
	task t_lead;
		wt(1);
		chk("por_hold", NR - 2, NR + 4, el());
		t0 = $time;
		pulse(15, 30);
		pulse(15, 5);
		wt(0);
		chk("lead_time", L - 2, L + 3, el());
		t0 = $time;
		pulse(25, 5);
		wt(1);
		chk("reset_pulse", NR - 2, NR + 3, el());
		t0 = $time;
		wt(0);
		chk("lead_again", L - 2, L + 3, el());
		wt(1);
	endtask
	task t_window;
		n = low_b;
		repeat (4) pulse(25, 55);
		chk("window_ok", n, n, low_b);
		t0 = $time;
		wt(0);
		chk("open_expiry", 38, 48, el());
	endtask
	task t_closed;
		wt(1);
		pulse(25, 5);
		lb.watchdog_trigger_n <= 1'b0;
		t0 = $time;
		wt(0);
		chk("closed_trig", 20, 26, el());
		@(posedge sys_clk);
		lb.watchdog_trigger_n <= 1'b1;
		wt(1);
	endtask
	task t_lowpow;
		@(posedge sys_clk);
		lp_b <= 1'b1;
		cyc(10);
		n = low_b;
		cyc(2 * L);
		chk("sleep_quiet", n, n, low_b);
		lp_b <= 1'b0;
		cyc(10);
		rx_b <= 1'b0;
		t0 = $time;
		wt(0);
		chk("wake_lead", L - 1, L + 6, el());
		@(posedge sys_clk);
		rx_b <= 1'b1;
	endtask
	task t_host;
		n = low_a;
		cyc(300);
		chk("host_alive", n, n, low_a);
		trig_en <= 1'b0;
		cyc(150);
		chk("host_reset", 1, 1, int'(low_a > n));
		lp_a <= 1'b1;
		cyc(20);
		lp_a <= 1'b0;
		cyc(10);
		n = low_a;
		rx_a <= 1'b0;
		cyc(70);
		chk("wake_a_lead", n, n, low_a);
		cyc(20);
		chk("wake_a_expiry", 1, 1, int'(low_a > n));
		rx_a <= 1'b1;
	endtask
	initial
	begin
		lb.watchdog_trigger_n = 1'b1;
		cyc(12);
		rst <= 1'b0;
		trig_en <= 1'b1;
		t0 = $time;
		t_lead();
		t_window();
		t_closed();
		t_lowpow();
		t_host();
		test_done();
	end
	initial
	begin
		#100000;
		num_errors++;
		test_done();
	end
endmodule

// *** tb/window_watchdog_properties.sv ***
// Assertions on link a, where both ends are design modules.
// Assumes one clock and a synchronous reset.
module window_watchdog_properties #(
	parameter int NRES_CYCLES = 50,
	parameter int POR_CYCLES = 50
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// Watched signals
	input wire logic low_power_mode,
	input wire logic watchdog_trigger_n,
	input wire logic reset_n
);
	int lo_cnt;
	int hi_cnt;
	int tl_cnt;
	logic por_done;
	always_ff @(posedge sys_clk) lo_cnt <= reset_n ? 0 : lo_cnt + 1;
	always_ff @(posedge sys_clk) hi_cnt <= reset_n ? hi_cnt + 1 : 0;
	always_ff @(posedge sys_clk) tl_cnt <= watchdog_trigger_n ? 0 : tl_cnt + 1;
	// Cleared by rst so a second power-on is not judged as a watchdog pulse
	always_ff @(posedge sys_clk) por_done <= rst ? 1'b0 : por_done | reset_n;
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence por_hold;
		!reset_n [*8];
	endsequence
	sequence lp_held;
		(por_done && low_power_mode) [*6];
	endsequence
	AST_POR_HOLD: assert property ($fell(rst) |-> por_hold) else $error("por hold");
	AST_POR_LEN: assert property ($rose(reset_n) && !por_done |-> lo_cnt >= POR_CYCLES) else $error("por len");
	AST_NRES_LEN: assert property ($rose(reset_n) && por_done
		|-> lo_cnt inside {[NRES_CYCLES - 1:NRES_CYCLES + 2]}) else $error("pulse len");
	AST_REL_HOLD: assert property ($rose(reset_n) |-> reset_n [*8]) else $error("early drop");
	AST_DROP_MIN: assert property ($fell(reset_n) |-> hi_cnt >= 40) else $error("drop too soon");
	AST_LP_QUIET: assert property (lp_held |-> reset_n) else $error("reset in low power");
	AST_TRIG_IDLE: assert property ($fell(rst) |-> watchdog_trigger_n) else $error("trigger idle");
	AST_TRIG_LEN: assert property ($rose(watchdog_trigger_n) && reset_n |-> tl_cnt >= 20) else $error("short");
endmodule
